// *** logic/rtc_pkg.sv ***
// shared constants for the real-time clock and calendar
package rtc_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam logic [3:0] ADR_CTRL1 = 4'h0;
  localparam logic [3:0] ADR_CTRL2 = 4'h1;
  localparam logic [3:0] ADR_SEC = 4'h2;
  localparam logic [3:0] ADR_YEAR = 4'h8;
  localparam logic [3:0] ADR_AMIN = 4'h9;
  localparam logic [3:0] ADR_AWDAY = 4'hC;
  localparam logic [3:0] ADR_SQW = 4'hD;
  localparam logic [3:0] ADR_TCTL = 4'hE;
  localparam logic [3:0] ADR_TVAL = 4'hF;
  localparam int BIT_STOP = 5;
  localparam int BIT_AF = 3;
  localparam int BIT_TF = 2;
  localparam int BIT_AIE = 1;
  localparam int BIT_TIE = 0;
  localparam int BIT_FE = 7;
  localparam int BIT_TE = 7;
  localparam int BIT_AE = 7;
  localparam logic [7:0] MASK_CTRL1 = 8'h20;
  localparam logic [7:0] MASK_CTRL2 = 8'h13;
  localparam logic [7:0] MASK_SQW = 8'h83;
  localparam logic [7:0] MASK_TCTL = 8'h83;
  localparam logic [7:0] RST_SQW = 8'h80;
  localparam logic [7:0] RST_ALARM = 8'h80;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam int NUM_CNT = 7;
  localparam int NUM_ALM = 4;
  localparam int CNT_SEC = 0;
  localparam int CNT_MIN = 1;
  localparam int CNT_HOUR = 2;
  localparam int CNT_DAY = 3;
  localparam int CNT_WDAY = 4;
  localparam int CNT_MON = 5;
  localparam int CNT_YEAR = 6;
  localparam logic [7:0] CNT_LO [NUM_CNT] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] CNT_HI [NUM_CNT] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
  localparam logic [7:0] CNT_MASK [NUM_CNT] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h1F, 8'hFF};
  localparam logic [7:0] ALM_MASK [NUM_ALM] = '{8'hFF, 8'hBF, 8'hBF, 8'h87};
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DAYS_FEB = 8'h28;
  localparam logic [7:0] DAYS_LEAP = 8'h29;
  localparam logic [7:0] DAYS_SHORT = 8'h30;
  localparam logic [3:0] LEAP_ODD_A = 4'h2;
  localparam logic [3:0] LEAP_ODD_B = 4'h6;
  localparam logic [3:0] LEAP_EVEN_A = 4'h0;
  localparam logic [3:0] LEAP_EVEN_B = 4'h4;
  localparam logic [3:0] LEAP_EVEN_C = 4'h8;
  localparam int DIV_W = 15;
  localparam int TAP_1K = 4;
  localparam int TAP_32 = 9;
  localparam int TAP_1HZ = 14;
  localparam logic [7:0] TIMER_LAST = 8'h01;
  typedef enum logic [1:0] {FD_32K, FD_1K, FD_32, FD_1HZ} freq_sel_t;
endpackage : rtc_pkg

// *** logic/sync2.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2
  import rtc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2

// *** logic/bcd_counter.sv ***
// one bcd time counter with load, wrap and carry
`timescale 1ns/10ps
module bcd_counter
  import rtc_pkg::*;
#(
  parameter logic [7:0] LO = 8'h00
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic [7:0] hi,
  output logic [7:0] value_r,
  output logic wrap
);
  logic [7:0] bump;
  logic [7:0] value_nxt;

  assign wrap = inc && (value_r >= hi);
  // decimal carry from the low digit into the high digit
  assign bump = (value_r[3:0] >= DIGIT_MAX) ? {value_r[7:4] + 4'h1, 4'h0} : value_r + 8'h01;
  assign value_nxt = load ? load_val : (wrap ? LO : (inc ? bump : value_r));

  always_ff @(posedge clk)
  begin
    if (!rstn)
      value_r <= LO;
    else
      value_r <= value_nxt;
  end

  a_bcd_digit_legal: assert property (@(posedge clk) disable iff (!rstn)
    inc && !load && value_r[3:0] <= DIGIT_MAX |=> value_r[3:0] <= DIGIT_MAX)
    else $error("counter low digit left bcd range");
  a_bcd_wrap_low: assert property (@(posedge clk) disable iff (!rstn)
    wrap && !load |=> value_r == LO)
    else $error("counter did not wrap to its lowest value");
endmodule : bcd_counter

// *** logic/rtc_core.sv ***
// real-time clock: serial slave, register bank, calendar, alarm, timer, square wave
// Function
// - the serial slave answers address byte A2h for writes and A3h for reads.
// - the serial bus runs at up to 400 kbit/s; the test master clocks one bit per 36 clk cycles (360 ns), faster than that.
// - the word pointer steps by one after each data byte written or read.
// - sixteen 8-bit registers are addressable, some bits unimplemented.
// - addresses 00h and 01h hold the two control and status registers.
// - addresses 02h to 08h hold seconds, minutes, hours, days, weekdays, months, years.
// - addresses 09h to 0Ch hold the minute, hour, day and weekday alarm registers.
// - address 0Dh selects the square-wave frequency.
// - address 0Eh is the countdown control and 0Fh the countdown value.
// - time counters and alarm registers are held in bcd.
// - a divider on the 32.768 kHz crystal makes the clock that advances time.
// - the square wave runs at 32.768 kHz, 1.024 kHz, 32 Hz or 1 Hz.
// - a disabled square wave is driven steadily low.
// - the interrupt output is open-drain, active low, pulled low when asserted.
`timescale 1ns/10ps
module rtc_core
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic crystal_in,
  output logic crystal_out,
  input wire logic square_wave_out_gate,
  output logic square_wave_out,
  output logic int_out,
  output logic int_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_RECV, ST_WACK, ST_RDATA,
    ST_RACK} slave_state_t;

  // ***************************************************************
  // pin synchronisers and edges
  // ***************************************************************
  logic scl_s, sda_s, gate_s, xtal_s;
  logic scl_d, sda_d, xtal_d;
  logic scl_rise, scl_fall, bus_start, bus_stop, xtal_rise;

  // reset to the idle pin levels so no false edge follows reset
  sync2 #(.W(4), .INIT(4'hC)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({scl_in, sda_in, square_wave_out_gate, crystal_in}),
    .q({scl_s, sda_s, gate_s, xtal_s})
  );

  always_ff @(posedge clk)
  begin
    if (!rstn)
      {scl_d, sda_d, xtal_d} <= 3'h6;
    else
      {scl_d, sda_d, xtal_d} <= {scl_s, sda_s, xtal_s};
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign xtal_rise = xtal_s && !xtal_d;

  // ***************************************************************
  // serial slave
  // ***************************************************************
  slave_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt, word_phase_r, word_phase_nxt, oe_r, oe_nxt;
  logic wr_en, rd_load, addr_hit;
  logic [7:0] rd_data;
  logic [7:0] rd_bank [16];

  assign addr_hit = shift_r[7:1] == SLAVE_ADDR;
  assign rd_data = rd_bank[ptr_r];

  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    word_phase_nxt = word_phase_r;
    oe_nxt = oe_r;
    wr_en = 1'b0;
    rd_load = 1'b0;
    if (bus_start)
    begin
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 3'h0;
      oe_nxt = 1'b0;
    end
    else if (bus_stop)
    begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR, ST_RECV:
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
              state_nxt = (state_r == ST_ADDR) ? ST_AACK : ST_WACK;
          end
        ST_AACK:
          if (scl_fall && !oe_r)
          begin
            oe_nxt = addr_hit;
            rw_nxt = shift_r[0];
            word_phase_nxt = 1'b1;
            if (!addr_hit)
              state_nxt = ST_IDLE;
          end
          else if (scl_fall)
          begin
            rd_load = rw_r;
            oe_nxt = rw_r && !rd_data[7];
            state_nxt = rw_r ? ST_RDATA : ST_RECV;
          end
        ST_WACK:
          if (scl_fall && !oe_r)
          begin
            oe_nxt = 1'b1;
            wr_en = !word_phase_r;
            ptr_nxt = word_phase_r ? shift_r[3:0] : ptr_r + 4'h1;
            word_phase_nxt = 1'b0;
          end
          else if (scl_fall)
          begin
            oe_nxt = 1'b0;
            state_nxt = ST_RECV;
          end
        ST_RDATA:
          if (scl_fall && bit_cnt_r == 3'h7)
          begin
            oe_nxt = 1'b0;
            bit_cnt_nxt = 3'h0;
            state_nxt = ST_RACK;
          end
          else if (scl_fall)
          begin
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = !tx_r[6];
          end
        ST_RACK:
          if (scl_rise && sda_s)
            state_nxt = ST_IDLE;
          else if (scl_fall)
          begin
            rd_load = 1'b1;
            oe_nxt = !rd_data[7];
            state_nxt = ST_RDATA;
          end
      endcase
    end
    if (rd_load)
    begin
      tx_nxt = rd_data;
      bit_cnt_nxt = 3'h0;
      ptr_nxt = ptr_r + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      {shift_r, tx_r} <= 16'h0000;
      ptr_r <= ADR_CTRL1;
      {rw_r, word_phase_r, oe_r} <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      {shift_r, tx_r} <= {shift_nxt, tx_nxt};
      ptr_r <= ptr_nxt;
      {rw_r, word_phase_r, oe_r} <= {rw_nxt, word_phase_nxt, oe_nxt};
    end
  end

  // ***************************************************************
  // register bank
  // ***************************************************************
  logic [15:0] wr_sel;
  logic stop_r, af_r, tf_r, tip_r;
  logic [1:0] c2_en_r;
  logic [7:0] alarm_r [NUM_ALM];
  logic [7:0] sqw_r, tctl_r, timer_r, trld_r;
  logic [7:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_inc, cnt_wrap;
  logic alarm_hit, timer_hit;

  assign wr_sel = wr_en ? (16'h0001 << ptr_r) : 16'h0000;

  // flags: hardware set wins over a clearing write of zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      {stop_r, af_r, tf_r, tip_r, c2_en_r} <= 6'h00;
      sqw_r <= RST_SQW;
      {tctl_r, trld_r} <= 16'h0000;
      for (int k = 0; k < NUM_ALM; k++)
        alarm_r[k] <= RST_ALARM;
    end
    else
    begin
      if (wr_sel[ADR_CTRL1])
        stop_r <= shift_r[BIT_STOP];
      if (wr_sel[ADR_CTRL2])
        {tip_r, c2_en_r} <= {shift_r[4], shift_r[BIT_AIE], shift_r[BIT_TIE]};
      af_r <= alarm_hit || (af_r && !(wr_sel[ADR_CTRL2] && !shift_r[BIT_AF]));
      tf_r <= timer_hit || (tf_r && !(wr_sel[ADR_CTRL2] && !shift_r[BIT_TF]));
      for (int k = 0; k < NUM_ALM; k++)
        if (wr_sel[ADR_AMIN + 4'(k)])
          alarm_r[k] <= shift_r & ALM_MASK[k];
      if (wr_sel[ADR_SQW])
        sqw_r <= shift_r & MASK_SQW;
      if (wr_sel[ADR_TCTL])
        tctl_r <= shift_r & MASK_TCTL;
      if (wr_sel[ADR_TVAL])
        trld_r <= shift_r;
    end
  end

  assign rd_bank[ADR_CTRL1] = {2'h0, stop_r, 5'h00} & MASK_CTRL1;
  assign rd_bank[ADR_CTRL2] = {3'h0, tip_r, af_r, tf_r, c2_en_r};
  assign rd_bank[ADR_SQW] = sqw_r;
  assign rd_bank[ADR_TCTL] = tctl_r;
  assign rd_bank[ADR_TVAL] = timer_r;

  // ***************************************************************
  // divider and calendar
  // ***************************************************************
  logic [DIV_W-1:0] div_r;
  logic sec_tick, leap;
  logic [7:0] day_hi, mon_v;

  // stop holds the divider cleared, as the time chain must freeze
  always_ff @(posedge clk)
  begin
    if (!rstn || stop_r)
      div_r <= '0;
    else if (xtal_rise)
      div_r <= div_r + 1'b1;
  end

  assign sec_tick = xtal_rise && (&div_r) && !stop_r;
  assign mon_v = cnt_val[CNT_MON];
  assign leap = cnt_val[CNT_YEAR][4] ?
    (cnt_val[CNT_YEAR][3:0] == LEAP_ODD_A || cnt_val[CNT_YEAR][3:0] == LEAP_ODD_B) :
    (cnt_val[CNT_YEAR][3:0] == LEAP_EVEN_A || cnt_val[CNT_YEAR][3:0] == LEAP_EVEN_B ||
     cnt_val[CNT_YEAR][3:0] == LEAP_EVEN_C);
  assign day_hi = (mon_v == MON_FEB) ? (leap ? DAYS_LEAP : DAYS_FEB) :
    ((mon_v == MON_APR || mon_v == MON_JUN || mon_v == MON_SEP || mon_v == MON_NOV) ?
     DAYS_SHORT : CNT_HI[CNT_DAY]);
  assign cnt_inc = {cnt_wrap[CNT_MON], cnt_wrap[CNT_DAY], cnt_wrap[CNT_HOUR],
    cnt_wrap[CNT_HOUR], cnt_wrap[CNT_MIN], cnt_wrap[CNT_SEC], sec_tick};

  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_cnt
    bcd_counter #(.LO(CNT_LO[i])) u_cnt (
      .clk(clk),
      .rstn(rstn),
      .inc(cnt_inc[i]),
      .load(wr_sel[ADR_SEC + 4'(i)]),
      .load_val(shift_r & CNT_MASK[i]),
      .hi((i == CNT_DAY) ? day_hi : CNT_HI[i]),
      .value_r(cnt_val[i]),
      .wrap(cnt_wrap[i])
    );
    assign rd_bank[ADR_SEC + 4'(i)] = cnt_val[i];
  end

  // ***************************************************************
  // alarm and countdown
  // ***************************************************************
  logic alarm_chk_r;
  logic [NUM_ALM-1:0] alm_on, alm_ok;

  for (genvar k = 0; k < NUM_ALM; k++)
  begin : g_alm
    assign alm_on[k] = !alarm_r[k][BIT_AE];
    assign alm_ok[k] = !alm_on[k] || (alarm_r[k][6:0] == cnt_val[k + 1][6:0]);
    assign rd_bank[ADR_AMIN + 4'(k)] = alarm_r[k];
  end

  assign alarm_hit = alarm_chk_r && (|alm_on) && (&alm_ok);
  assign timer_hit = sec_tick && tctl_r[BIT_TE] && timer_r == TIMER_LAST;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      {alarm_chk_r, timer_r} <= 9'h000;
    else
    begin
      alarm_chk_r <= cnt_wrap[CNT_SEC];
      if (wr_sel[ADR_TVAL])
        timer_r <= shift_r;
      else if (timer_hit)
        timer_r <= trld_r;
      else if (sec_tick && tctl_r[BIT_TE] && timer_r != 8'h00)
        timer_r <= timer_r - TIMER_LAST;
    end
  end

  // ***************************************************************
  // pins
  // ***************************************************************
  logic sqw_src;
  freq_sel_t fd;

  assign fd = freq_sel_t'(sqw_r[1:0]);
  assign sqw_src = (fd == FD_32K) ? xtal_s : (fd == FD_1K) ? div_r[TAP_1K] :
    (fd == FD_32) ? div_r[TAP_32] : div_r[TAP_1HZ];

  always_ff @(posedge clk)
  begin
    if (!rstn)
      {square_wave_out, int_oe, int_out, sda_out, sda_oe, crystal_out} <= 6'h00;
    else
    begin
      square_wave_out <= gate_s && sqw_r[BIT_FE] && sqw_src;
      int_oe <= (af_r && c2_en_r[1]) || (tf_r && c2_en_r[0]);
      int_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= oe_r;
      crystal_out <= !xtal_s;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_addr_ack_match: assert property (
    state_r == ST_AACK && scl_fall && !oe_r && !bus_start && !bus_stop
    |=> oe_r == $past(addr_hit)) else $error("address acknowledge wrong");
  a_ptr_step_write: assert property (wr_en |=> ptr_r == $past(ptr_r) + 4'h1)
    else $error("pointer did not step after write");
  a_ptr_step_read: assert property (rd_load |=> ptr_r == $past(ptr_r) + 4'h1)
    else $error("pointer did not step after read");
  a_ptr_wrap_top: assert property (wr_en && ptr_r == ADR_TVAL |=> ptr_r == ADR_CTRL1)
    else $error("pointer did not wrap");
  a_ctrl_enables: assert property (
    wr_en && ptr_r == ADR_CTRL2 |=> c2_en_r == $past(shift_r[1:0]))
    else $error("control enables not stored");
  a_time_load: assert property (
    wr_en && ptr_r == ADR_YEAR |=> cnt_val[CNT_YEAR] == $past(shift_r))
    else $error("year register not loaded");
  a_sec_source: assert property (
    $changed(cnt_val[CNT_SEC]) |-> $past(sec_tick) || $past(wr_sel[ADR_SEC]))
    else $error("seconds moved without a tick");
  a_sqw_one_hz: assert property (
    gate_s && sqw_r[BIT_FE] && fd == FD_1HZ |=> square_wave_out == $past(div_r[TAP_1HZ]))
    else $error("square wave not on selected tap");
  a_sqw_held_low: assert property (
    !gate_s || !sqw_r[BIT_FE] |=> !square_wave_out) else $error("square wave not low");
  a_int_pull_low: assert property (
    af_r && c2_en_r[1] |=> int_oe && !int_out) else $error("interrupt not pulled low");
  a_timer_reload: assert property (
    timer_hit && !wr_sel[ADR_TVAL] |=> tf_r && timer_r == $past(trld_r))
    else $error("countdown did not flag and reload");
  c_read_byte: cover property (rd_load ##1 state_r == ST_RDATA);
  c_write_byte: cover property (wr_en);
  c_alarm_flag: cover property (alarm_hit);
  c_timer_flag: cover property (timer_hit);
endmodule : rtc_core

// *** test/i2c_master_model.sv ***
// serial bus master model driving clock and data as open-drain enables
`timescale 1ns/10ps
module i2c_master_model
(
  input wire logic clk,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  // ****************************************
  // bus phases, each held a fixed clk count
  // ****************************************
  localparam int Q = 12;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic wait_q();
    repeat (Q) @(posedge clk);
  endtask : wait_q
  // also serves as repeated start from scl low
  task automatic start_cond();
    sda_oe <= 1'b0;
    wait_q();
    scl_oe <= 1'b0;
    wait_q();
    sda_oe <= 1'b1;
    wait_q();
    scl_oe <= 1'b1;
    wait_q();
  endtask : start_cond
  task automatic stop_cond();
    sda_oe <= 1'b1;
    wait_q();
    scl_oe <= 1'b0;
    wait_q();
    sda_oe <= 1'b0;
    wait_q();
  endtask : stop_cond
  // data changes only while scl is low
  task automatic wbit(input logic b);
    sda_oe <= ~b;
    wait_q();
    scl_oe <= 1'b0;
    wait_q();
    scl_oe <= 1'b1;
    wait_q();
  endtask : wbit
  task automatic rbit(output logic b);
    sda_oe <= 1'b0;
    wait_q();
    scl_oe <= 1'b0;
    repeat (Q / 2) @(posedge clk);
    b = sda;
    repeat (Q - Q / 2) @(posedge clk);
    scl_oe <= 1'b1;
    wait_q();
  endtask : rbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(b);
    ack = ~b;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask : rbyte
endmodule : i2c_master_model

// *** test/rtc_register_map_and_clock_out_tb.sv ***
// self-checking bench for the real-time clock register map and square wave
`timescale 1ns/10ps
module rtc_register_map_and_clock_out_tb;
  import rtc_pkg::*;
  logic clk, rstn, crystal_in, square_wave_out_gate, scl_wire, sda_wire;
  logic dut_sda_out, dut_sda_oe, crystal_out, square_wave_out, int_out, int_oe;
  logic m_scl_oe, m_sda_oe, ack;
  int fails, n_checks, n;
  logic [7:0] rst_tbl [$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
    8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] sq_sel [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h03};
  int sq_win [5] = '{256, 2048, 16384, 4096, 4096};
  int sq_lo [5] = '{62, 14, 3, 0, 0};
  int sq_hi [5] = '{66, 18, 5, 1, 0};
  // ****************************************
  // design, master model and pulled-up wires
  // ****************************************
  assign scl_wire = ~m_scl_oe;
  assign sda_wire = ~(m_sda_oe | dut_sda_oe);
  rtc_core i_dut (.clk(clk), .rstn(rstn), .scl_in(scl_wire), .sda_in(sda_wire),
    .sda_out(dut_sda_out), .sda_oe(dut_sda_oe), .crystal_in(crystal_in),
    .crystal_out(crystal_out), .square_wave_out_gate(square_wave_out_gate),
    .square_wave_out(square_wave_out), .int_out(int_out), .int_oe(int_oe));
  i2c_master_model i_master (.clk(clk), .sda(sda_wire), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    crystal_in = 1'b0;
    square_wave_out_gate = 1'b0;
  end
  always #5 clk = ~clk;
  always
  begin
    repeat (4) @(posedge clk);
    crystal_in <= ~crystal_in;
  end
  // ****************************************
  // compare, bus access and closing tasks
  // ****************************************
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte
  task automatic check_count(input string name, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_count
  task automatic set_ptr(input logic [7:0] adr);
    i_master.start_cond();
    i_master.wbyte(8'hA2, ack);
    check_byte("write address ack", 8'h01, {7'h00, ack});
    i_master.wbyte(adr, ack);
    check_byte("word address ack", 8'h01, {7'h00, ack});
  endtask : set_ptr
  task automatic reg_write(input logic [7:0] adr, input logic [7:0] d [$]);
    set_ptr(adr);
    foreach (d[i])
    begin
      i_master.wbyte(d[i], ack);
      check_byte("data ack", 8'h01, {7'h00, ack});
    end
    i_master.stop_cond();
  endtask : reg_write
  task automatic reg_read(input logic [7:0] adr, input logic [7:0] exp [$]);
    logic [7:0] got;
    set_ptr(adr);
    i_master.start_cond();
    i_master.wbyte(8'hA3, ack);
    check_byte("read address ack", 8'h01, {7'h00, ack});
    foreach (exp[i])
    begin
      i_master.rbyte(i == exp.size() - 1, got);
      check_byte("register read", exp[i], got);
    end
    i_master.stop_cond();
  endtask : reg_read
  task automatic count_edges(input int span, input bit xtal, output int cnt);
    logic prev;
    cnt = 0;
    @(negedge clk);
    prev = xtal ? crystal_out : square_wave_out;
    repeat (span)
    begin
      @(negedge clk);
      if ((xtal ? crystal_out : square_wave_out) !== prev) cnt++;
      prev = xtal ? crystal_out : square_wave_out;
    end
    @(posedge clk);
  endtask : count_edges
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    reg_read(8'h00, rst_tbl);
    i_master.start_cond();
    i_master.wbyte(8'hA4, ack);
    check_byte("foreign address ack", 8'h00, {7'h00, ack});
    i_master.stop_cond();
    reg_write({4'h0, ADR_TCTL}, '{8'h03, 8'h5A, 8'h00, 8'h13});
    reg_read({4'h0, ADR_TCTL}, '{8'h03, 8'h5A, 8'h00, 8'h13});
    reg_write(8'h03, '{8'h45, 8'h23, 8'h15, 8'h03, 8'h11, 8'h24});
    reg_read(8'h03, '{8'h45, 8'h23, 8'h15, 8'h03, 8'h11, 8'h24});
    count_edges(64, 1'b1, n);
    check_count("oscillator output edges", 15, 17, n);
    reg_write({4'h0, ADR_AMIN}, '{8'h59});
    reg_read({4'h0, ADR_AMIN}, '{8'h59});
    count_edges(512, 1'b0, n);
    check_count("gated square wave edges", 0, 0, n);
    check_byte("gated square wave level", 8'h00, {7'h00, square_wave_out});
    square_wave_out_gate <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      reg_write({4'h0, ADR_SQW}, '{sq_sel[i]});
      repeat (16) @(posedge clk);
      count_edges(sq_win[i], 1'b0, n);
      check_count("square wave edges", sq_lo[i], sq_hi[i], n);
    end
    check_byte("disabled square wave level", 8'h00, {7'h00, square_wave_out});
    check_byte("interrupt released", 8'h00, {6'h00, int_oe, int_out});
    check_byte("data drive value", 8'h00, {7'h00, dut_sda_out});
    stop_test();
  end
endmodule : rtc_register_map_and_clock_out_tb
